//--- test/ssd_peer.sv
`timescale 1ns/10ps
// Clocked serial peer: drives the shift clock only within frames and flips its data bit 60 ns after each one
module ssd_peer (
  // Serial link
  output logic sclk,
  output logic sdo,
  input wire logic sdi
);
  logic [7:0] got;

  initial begin
    sclk = 1'b1;
    sdo = 1'b0;
    got = 8'h00;
  end

  // Peer shifts on the falling edge and samples on the rising one
  task automatic xfer(input logic [7:0] tx);
    for (int i = 7; i >= 0; i--) begin
      #62.5;
      sclk = 1'b0;
      sdo = tx[i];
      #62.5;
      sclk = 1'b1;
      got[i] = sdi;
    end
    // Hold past the device's sampling delay, then stop showing the bit
    #60;
    sdo = ~sdo;
  endtask
endmodule

//--- test/test_sync_serial_full_duplex_stop.sv
`timescale 1ns/10ps
module test_sync_serial_full_duplex_stop;
  localparam logic [7:0] a_dat = ssd_pkg::OFF_DATA;
  localparam logic [7:0] a_ctl = ssd_pkg::OFF_CTRL;
  localparam logic [7:0] a_sta = ssd_pkg::OFF_STAT;
  localparam logic [7:0] a_irq = ssd_pkg::OFF_IRQ_ST;
  localparam logic [7:0] a_msk = ssd_pkg::OFF_IRQ_MASK;
  logic pclk, presetn, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, slv, sck, sdo_peer, so, oe, irq;
  int failures, n_checks, cyc;

  ssd_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_clock_pin_in(sck), .serial_clock_pin_out(),
    .serial_clock_pin_oe(oe), .serial_in_pin(sdo_peer),
    .serial_out_pin(so), .transfer_irq(irq));
  ssd_peer peer (.sclk(sck), .sdo(sdo_peer), .sdi(so));

  always #5 pclk = ~pclk;

  // Whole run is under a thousand cycles; this only catches a hang
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      test_done;
    end
  end

  task automatic test_done;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string w, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask

  // Read data and error are taken at the edge where pready is seen high
  task automatic apb(input logic wr_en, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      failures++;
      $display("CHECK FAILED pready expected 1 seen %b", pready);
    end
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input string w);
    apb(1'b0, a, 32'h0);
    chk(w, e, rd);
  endtask

  task automatic xb(input logic [7:0] rx, input logic [7:0] tx);
    peer.xfer(rx);
    repeat (8) @(posedge pclk);
    chk("byte on link", {24'h0, tx}, {24'h0, peer.got});
  endtask

  task automatic t_reset;
    rc(a_sta, 32'h0, "status at reset");
    chk("out at reset", 32'h1, {31'h0, so});
    chk("irq at reset", 32'h0, {31'h0, irq});
  endtask

  task automatic t_run;
    wr(a_msk, 32'h7);
    wr(a_dat, 32'ha5);
    wr(a_ctl, 32'h7);
    rc(a_sta, 32'h3, "status after start");
    chk("irq pin", 32'h1, {31'h0, irq});
    rc(a_irq, 32'h1, "irq status");
    wr(a_irq, 32'h7);
    wr(a_dat, 32'h5a);
    rc(a_sta, 32'h7, "status buffer full");
    wr(a_dat, 32'h6a);
    xb(8'h3c, 8'ha5);
    xb(8'hc3, 8'h6a);
    rc(a_sta, 32'h1b, "status overrun");
    xb(8'h96, 8'h6a);
    rc(a_sta, 32'h3b, "status underrun");
    rc(a_sta, 32'h2b, "status after read");
    rc(a_dat, 32'h3c, "rx kept on overrun");
  endtask

  task automatic t_stop;
    wr(a_msk, 32'h0);
    wr(a_irq, 32'h7);
    fork
      xb(8'h55, 8'h6a);
      begin
        repeat (30) @(posedge pclk);
        wr(a_ctl, 32'h6);
      end
    join
    apb(1'b0, a_irq, 32'h0);
    chk("irq after stop", 32'h1, {31'h0, rd[0]});
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(a_msk, 32'h1);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(a_irq, 32'h1);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rc(a_sta, 32'h28, "status after stop");
    chk("held out", 32'h0, {31'h0, so});
    rc(a_dat, 32'h55, "rx after stop");
    peer.xfer(8'hff);
    repeat (8) @(posedge pclk);
    rc(a_sta, 32'h20, "status ignores clock");
    chk("out still held", 32'h0, {31'h0, so});
  endtask

  task automatic t_abort;
    wr(a_ctl, 32'h0);
    chk("out after mode off", 32'h1, {31'h0, so});
    rc(a_sta, 32'h0, "status mode off");
    wr(a_dat, 32'h0f);
    wr(a_ctl, 32'h7);
    fork
      peer.xfer(8'h00);
      begin
        repeat (30) @(posedge pclk);
        wr(a_ctl, 32'h0);
        rc(a_sta, 32'h0, "status aborted");
        chk("out aborted", 32'h1, {31'h0, so});
      end
    join
    rc(a_ctl, 32'h0, "start cleared");
    chk("clock pin off", 32'h0, {31'h0, oe});
  endtask

  task automatic t_quick;
    wr(a_dat, 32'h11);
    wr(a_ctl, 32'h7);
    wr(a_irq, 32'h7);
    wr(a_ctl, 32'h6);
    rc(a_sta, 32'h0, "status quick stop");
    rc(a_irq, 32'h0, "irq quick stop");
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, slv});
    chk("unmapped data", 32'h0, rd);
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    failures = 0;
    n_checks = 0;
    cyc = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_run;
    t_stop;
    t_abort;
    t_quick;
    test_done;
  end
endmodule

//--- verilog/ssd_pkg.sv
package ssd_pkg;
  // Register byte offsets on APB
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_ST = 8'h0c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  // Control register fields
  localparam int CTRL_START = 0;
  localparam int CTRL_MODE_LO = 1;
  localparam int CTRL_INTCLK = 3;
  localparam int CTRL_EDGE = 4;
  localparam int CTRL_LSB = 5;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_DUPLEX = 2'h3;
  // Status register fields
  localparam int ST_PROG = 0;
  localparam int ST_SHIFT = 1;
  localparam int ST_TBFL = 2;
  localparam int ST_REND = 3;
  localparam int ST_OERR = 4;
  localparam int ST_UERR = 5;
  // Interrupt status fields
  localparam int IRQ_XFER = 0;
  localparam int IRQ_UERR = 1;
  localparam int IRQ_OERR = 2;
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [5:0] STAT_RST = 6'h00;
  localparam logic [2:0] IRQ_RST = 3'h0;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam int SYNC_STAGES = 2;
  typedef enum logic [1:0] {
    SS_IDLE,
    SS_RUN,
    SS_LAST
  } ssd_state_t;
endpackage

//--- verilog/ssd_sync.sv
`timescale 1ns/10ps
// Two-flop level synchroniser; only the last stage is visible outside
module ssd_sync #(
  parameter int STAGES = 2
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Level
  input wire logic d,
  output logic q
);
  logic [STAGES-1:0] sync_ff;
  logic [STAGES-1:0] nxt_sync;

  always_comb begin
    nxt_sync = {sync_ff[STAGES-2:0], d};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_ff <= '0;
    end else begin
      sync_ff <= nxt_sync;
    end
  end

  assign q = sync_ff[STAGES-1];
endmodule

//--- verilog/ssd_top.sv
// Added by the designer: the APB register port and the address map.
`timescale 1ns/10ps
module ssd_top (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  // Interrupt
  output logic transfer_irq
);
  logic sclk_s, sin_s;
  logic sclk_d_ff, nxt_sclk_d;
  logic [5:0] ctrl_ff, nxt_ctrl;
  logic [5:0] stat_ff, nxt_stat;
  logic [2:0] ist_ff, nxt_ist;
  logic [2:0] imask_ff, nxt_imask;
  logic [7:0] wbuf_ff, nxt_wbuf;
  logic [7:0] rbuf_ff, nxt_rbuf;
  logic [7:0] shreg_ff, nxt_shreg;
  logic [7:0] last_tx_ff, nxt_last_tx;
  logic [2:0] bit_ff, nxt_bit;
  logic sout_ff, nxt_sout;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic irq_ff, nxt_irq;
  logic resend_ff, nxt_resend;
  ssd_pkg::ssd_state_t st_ff, nxt_st;
  logic acc, wr, rd, sh_edge, smp_edge, ext_clk;

  ssd_sync #(.STAGES(ssd_pkg::SYNC_STAGES)) u_sclk (
    .pclk(pclk),
    .presetn(presetn),
    .d(serial_clock_pin_in),
    .q(sclk_s)
  );
  ssd_sync #(.STAGES(ssd_pkg::SYNC_STAGES)) u_sin (
    .pclk(pclk),
    .presetn(presetn),
    .d(serial_in_pin),
    .q(sin_s)
  );

  // One wait state lets read data settle before pready is seen high
  assign acc = psel && penable && !pready_ff;
  assign wr = psel && penable && pwrite && pready_ff;
  assign rd = psel && penable && !pwrite && pready_ff;
  assign ext_clk = !ctrl_ff[ssd_pkg::CTRL_INTCLK];
  // Edge select: 0 shifts out on falling and samples on rising
  assign smp_edge = ctrl_ff[ssd_pkg::CTRL_EDGE] ? (!sclk_s && sclk_d_ff)
                                                 : (sclk_s && !sclk_d_ff);
  assign sh_edge = ctrl_ff[ssd_pkg::CTRL_EDGE] ? (sclk_s && !sclk_d_ff)
                                                : (!sclk_s && sclk_d_ff);

  always_comb begin
    logic [1:0] wmode;
    logic [7:0] txb;
    logic rdbit;
    wmode = pwdata[ssd_pkg::CTRL_MODE_LO +: 2];
    txb = 8'h00;
    rdbit = 1'b0;
    nxt_sclk_d = sclk_s;
    nxt_ctrl = ctrl_ff;
    nxt_stat = stat_ff;
    nxt_ist = ist_ff;
    nxt_imask = imask_ff;
    nxt_wbuf = wbuf_ff;
    nxt_rbuf = rbuf_ff;
    nxt_shreg = shreg_ff;
    nxt_last_tx = last_tx_ff;
    nxt_bit = bit_ff;
    nxt_sout = sout_ff;
    nxt_st = st_ff;
    nxt_resend = resend_ff;
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    nxt_prdata = prdata_ff;

    // Serial engine; idle state ignores the clock pin
    unique case (st_ff)
      ssd_pkg::SS_IDLE: begin
      end
      ssd_pkg::SS_RUN, ssd_pkg::SS_LAST: begin
        // Underrun counts only once the peer clocks the re-sent copy
        if (resend_ff && (smp_edge || sh_edge)) begin
          nxt_resend = 1'b0;
          nxt_stat[ssd_pkg::ST_UERR] = 1'b1;
          nxt_ist[ssd_pkg::IRQ_UERR] = 1'b1;
        end
        if (smp_edge) begin
          nxt_shreg = ctrl_ff[ssd_pkg::CTRL_LSB] ? {sin_s, shreg_ff[7:1]}
                                                 : {shreg_ff[6:0], sin_s};
          nxt_bit = 3'(bit_ff + 3'h1);
          if (bit_ff == ssd_pkg::BIT_LAST) begin
            nxt_ist[ssd_pkg::IRQ_XFER] = 1'b1;
            if (stat_ff[ssd_pkg::ST_REND]) begin
              // Overrun keeps the older received byte
              nxt_stat[ssd_pkg::ST_OERR] = 1'b1;
              nxt_ist[ssd_pkg::IRQ_OERR] = 1'b1;
            end else begin
              nxt_rbuf = nxt_shreg;
            end
            nxt_stat[ssd_pkg::ST_REND] = 1'b1;
            if (st_ff == ssd_pkg::SS_LAST || !ctrl_ff[ssd_pkg::CTRL_START])
            begin
              nxt_st = ssd_pkg::SS_IDLE;
              nxt_stat[ssd_pkg::ST_PROG] = 1'b0;
              nxt_stat[ssd_pkg::ST_SHIFT] = 1'b0;
              nxt_stat[ssd_pkg::ST_TBFL] = 1'b0;
              if (!ext_clk) begin
                nxt_sout = 1'b1;
              end
            end else begin
              // Reload without waiting for software
              if (stat_ff[ssd_pkg::ST_TBFL]) begin
                txb = wbuf_ff;
                nxt_stat[ssd_pkg::ST_TBFL] = 1'b0;
                nxt_resend = 1'b0;
              end else begin
                txb = last_tx_ff;
                nxt_resend = 1'b1;
              end
              nxt_shreg = txb;
              nxt_last_tx = txb;
            end
          end
        end else if (sh_edge) begin
          nxt_sout = ctrl_ff[ssd_pkg::CTRL_LSB] ? shreg_ff[0] : shreg_ff[7];
        end
      end
    endcase

    // Register writes
    if (wr) begin
      unique case (paddr)
        ssd_pkg::OFF_DATA: begin
          nxt_wbuf = pwdata[7:0];
          if (st_ff == ssd_pkg::SS_IDLE) begin
            nxt_last_tx = pwdata[7:0];
          end else if (resend_ff && !smp_edge && !sh_edge) begin
            // Shifter only holds a re-send copy: the new byte replaces it
            nxt_shreg = pwdata[7:0];
            nxt_last_tx = pwdata[7:0];
            nxt_resend = 1'b0;
          end else begin
            nxt_stat[ssd_pkg::ST_TBFL] = 1'b1;
          end
        end
        ssd_pkg::OFF_CTRL: begin
          if (wmode == ssd_pkg::MODE_OFF) begin
            nxt_ctrl[ssd_pkg::CTRL_START] = 1'b0;
            nxt_ctrl[ssd_pkg::CTRL_MODE_LO +: 2] = ssd_pkg::MODE_OFF;
            nxt_stat = ssd_pkg::STAT_RST;
            nxt_st = ssd_pkg::SS_IDLE;
            nxt_resend = 1'b0;
            nxt_sout = 1'b1;
          end else if (st_ff != ssd_pkg::SS_IDLE) begin
            // Only start may change while running
            if (!pwdata[ssd_pkg::CTRL_START]) begin
              nxt_ctrl[ssd_pkg::CTRL_START] = 1'b0;
              if (stat_ff[ssd_pkg::ST_SHIFT] && bit_ff != 3'h0) begin
                nxt_st = ssd_pkg::SS_LAST;
              end else begin
                nxt_st = ssd_pkg::SS_IDLE;
                nxt_resend = 1'b0;
                nxt_stat[ssd_pkg::ST_PROG] = 1'b0;
                nxt_stat[ssd_pkg::ST_SHIFT] = 1'b0;
                nxt_stat[ssd_pkg::ST_TBFL] = 1'b0;
              end
            end
          end else begin
            nxt_ctrl = pwdata[5:0];
            if (pwdata[ssd_pkg::CTRL_START] && wmode == ssd_pkg::MODE_DUPLEX)
            begin
              nxt_st = ssd_pkg::SS_RUN;
              nxt_stat[ssd_pkg::ST_PROG] = 1'b1;
              nxt_stat[ssd_pkg::ST_SHIFT] = 1'b1;
              nxt_ist[ssd_pkg::IRQ_XFER] = 1'b1;
              nxt_shreg = wbuf_ff;
              nxt_last_tx = wbuf_ff;
              nxt_bit = 3'h0;
              nxt_resend = 1'b0;
            end else begin
              nxt_ctrl[ssd_pkg::CTRL_START] = 1'b0;
            end
          end
        end
        ssd_pkg::OFF_IRQ_ST: begin
          nxt_ist = nxt_ist & ~(ist_ff & pwdata[2:0]);
        end
        ssd_pkg::OFF_IRQ_MASK: begin
          nxt_imask = pwdata[2:0];
        end
        default: begin
        end
      endcase
    end

    // Read data and error settle in the first access cycle
    if (acc) begin
      nxt_pready = 1'b1;
      if (!pwrite) begin
        unique case (paddr)
          ssd_pkg::OFF_DATA: nxt_prdata = {24'h000000, rbuf_ff};
          ssd_pkg::OFF_CTRL: nxt_prdata = {26'h0000000, ctrl_ff};
          ssd_pkg::OFF_STAT: nxt_prdata = {26'h0000000, stat_ff};
          ssd_pkg::OFF_IRQ_ST: nxt_prdata = {29'h00000000, ist_ff};
          ssd_pkg::OFF_IRQ_MASK: nxt_prdata = {29'h00000000, imask_ff};
          default: begin
            nxt_prdata = 32'h00000000;
            nxt_pslverr = 1'b1;
          end
        endcase
      end else if (paddr != ssd_pkg::OFF_DATA && paddr != ssd_pkg::OFF_CTRL
                   && paddr != ssd_pkg::OFF_IRQ_ST
                   && paddr != ssd_pkg::OFF_IRQ_MASK) begin
        nxt_pslverr = 1'b1;
      end
    end

    // Read side effects happen only at the completing edge
    if (rd) begin
      if (paddr == ssd_pkg::OFF_DATA) begin
        rdbit = 1'b1;
      end
      // A same-cycle overrun still wins over the read clear
      if (paddr == ssd_pkg::OFF_STAT &&
          !(nxt_stat[ssd_pkg::ST_OERR] && !stat_ff[ssd_pkg::ST_OERR])) begin
        nxt_stat[ssd_pkg::ST_OERR] = 1'b0;
      end
    end
    if (rdbit && !(smp_edge && bit_ff == ssd_pkg::BIT_LAST &&
                   st_ff != ssd_pkg::SS_IDLE)) begin
      nxt_stat[ssd_pkg::ST_REND] = 1'b0;
    end
    nxt_irq = |(nxt_ist & nxt_imask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_d_ff <= 1'b0;
      ctrl_ff <= ssd_pkg::CTRL_RST;
      stat_ff <= ssd_pkg::STAT_RST;
      ist_ff <= ssd_pkg::IRQ_RST;
      imask_ff <= ssd_pkg::IRQ_RST;
      wbuf_ff <= ssd_pkg::DATA_RST;
      rbuf_ff <= ssd_pkg::DATA_RST;
      shreg_ff <= ssd_pkg::DATA_RST;
      last_tx_ff <= ssd_pkg::DATA_RST;
      bit_ff <= 3'h0;
      sout_ff <= 1'b1;
      st_ff <= ssd_pkg::SS_IDLE;
      resend_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      sclk_d_ff <= nxt_sclk_d;
      ctrl_ff <= nxt_ctrl;
      stat_ff <= nxt_stat;
      ist_ff <= nxt_ist;
      imask_ff <= nxt_imask;
      wbuf_ff <= nxt_wbuf;
      rbuf_ff <= nxt_rbuf;
      shreg_ff <= nxt_shreg;
      last_tx_ff <= nxt_last_tx;
      bit_ff <= nxt_bit;
      sout_ff <= nxt_sout;
      st_ff <= nxt_st;
      resend_ff <= nxt_resend;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      irq_ff <= nxt_irq;
    end
  end

  // Internal clock generation is outside this block: pin stays idle input
  assign serial_clock_pin_out = 1'b1;
  assign serial_clock_pin_oe = 1'b0;
  assign serial_out_pin = sout_ff;
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign transfer_irq = irq_ff;

  last_byte_ends_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_ff == ssd_pkg::SS_LAST && smp_edge && bit_ff == ssd_pkg::BIT_LAST
    && !wr |=> st_ff == ssd_pkg::SS_IDLE && !stat_ff[ssd_pkg::ST_SHIFT])
    else $error("reserved stop did not end after byte");
  abort_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == ssd_pkg::OFF_CTRL && pwdata[2:1] == ssd_pkg::MODE_OFF
    |=> stat_ff == 6'h00 && sout_ff && !ctrl_ff[ssd_pkg::CTRL_START])
    else $error("forced abort left state");
  start_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(stat_ff[ssd_pkg::ST_PROG]) |-> stat_ff[ssd_pkg::ST_SHIFT]
    && ist_ff[ssd_pkg::IRQ_XFER] && st_ff == ssd_pkg::SS_RUN)
    else $error("start did not set flags");
  idle_ignores_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_ff == ssd_pkg::SS_IDLE && !wr |=> $stable(shreg_ff) && $stable(rbuf_ff))
    else $error("shift while stopped");
  stop_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(stat_ff[ssd_pkg::ST_PROG]) |-> !stat_ff[ssd_pkg::ST_SHIFT]
    && !stat_ff[ssd_pkg::ST_TBFL])
    else $error("stop left flags set");
  underrun_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_ff == ssd_pkg::SS_RUN && ctrl_ff[0] && smp_edge && bit_ff == 3'h7
    && !stat_ff[ssd_pkg::ST_TBFL] && !wr
    |=> resend_ff && shreg_ff == $past(last_tx_ff))
    else $error("underrun reload wrong");
  uerr_on_clock_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_ff != ssd_pkg::SS_IDLE && resend_ff && (smp_edge || sh_edge)
    && !wr |=> stat_ff[ssd_pkg::ST_UERR] && ist_ff[ssd_pkg::IRQ_UERR])
    else $error("underrun not flagged");
  overrun_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_ff != ssd_pkg::SS_IDLE && smp_edge && bit_ff == 3'h7 && !wr
    && stat_ff[ssd_pkg::ST_REND] |=> stat_ff[ssd_pkg::ST_OERR]
    && $stable(rbuf_ff))
    else $error("overrun not flagged");
  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    transfer_irq == |(ist_ff & imask_ff))
    else $error("irq output wrong");
endmodule
